// ---- verilog/emsd_pkg.sv ----
package emsd_pkg;
   localparam logic [31:0] SRAM_BASE   = 32'h8000_0000;
   localparam logic [31:0] SRAM_BYTES  = 32'h0000_2000;
   localparam logic [31:0] TRAP_BASE   = 32'h8000_0040;
   localparam logic [31:0] FREE_BASE   = 32'h8000_0140;
   localparam int          PHASES_PER_CYCLE = 2;

   localparam logic [1:0]  SZ32 = 2'h0;
   localparam logic [1:0]  SZ16 = 2'h1;
   localparam logic [1:0]  SZ8  = 2'h2;

   localparam logic [1:0]  BANK_PERIPH = 2'h2;
   localparam logic [1:0]  RGN_CHAN    = 2'h0;
   localparam logic [1:0]  RGN_TRAP    = 2'h1;
   localparam logic [1:0]  RGN_FREE    = 2'h2;

   localparam logic [7:0]  BANK0_CFG_OFFSET = 8'h00;
   localparam logic [7:0]  BANK1_CFG_OFFSET = 8'h04;
   localparam logic [7:0]  BANK2_CFG_OFFSET = 8'h08;
   localparam logic [7:0]  BANK3_CFG_OFFSET = 8'h0c;
   localparam logic [7:0]  CAS_MODE_OFFSET  = 8'h10;
   localparam logic [7:0]  RFSH_TIME_OFFSET = 8'h14;
   localparam logic [7:0]  STATUS_OFFSET    = 8'h18;
   localparam logic [7:0]  FREE_LOC_OFFSET  = 8'h1c;
   localparam int          BANK_CFG_W       = 15;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {S_IDLE, S_ROW, S_COL, S_RFSH} emsd_state_t;

   typedef struct packed {
      logic [3:0] col_ph;
      logic [3:0] row_ph;
      logic       gp_col;
      logic       gp_row;
      logic       be_wr;
      logic       be_rd;
      logic       mux;
      logic [1:0] size;
   } emsd_bank_cfg_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  mask;
      logic        write;
      logic        device;
   } emsd_req_t;

   typedef struct packed {
      logic [21:0] addr;
      logic [3:0]  be_n;
      logic [2:0]  ras_n;
      logic [3:0]  cas_n;
      logic [31:0] dout;
      logic [3:0]  doe;
   } emsd_pins_t;

   localparam emsd_bank_cfg_t BANK_CFG_RST = '{col_ph: 4'h4, row_ph: 4'h0, gp_col: 1'b1,
      gp_row: 1'b0, be_wr: 1'b1, be_rd: 1'b1, mux: 1'b0, size: SZ32};
   localparam logic [3:0]  RFSH_PH_RST  = 4'h4;
   localparam logic [3:0]  CAS_BYTE_RST = 4'h0;
   localparam emsd_pins_t  PINS_IDLE    = '{addr: 22'h0, be_n: 4'hf, ras_n: 3'h7,
      cas_n: 4'hf, dout: 32'h0, doe: 4'h0};
endpackage

// ---- verilog/emsd_lane_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module emsd_lane_map
(
   input  wire logic [1:0]  size,
   input  wire logic [1:0]  a_lo,
   input  wire logic [3:0]  mask,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] din,
   output logic      [3:0]  be_n,
   output logic      [3:0]  is_addr,
   output logic      [3:0]  lanes,
   output logic      [31:0] bus_wdata,
   output logic      [31:0] rword
);
   logic [1:0] sel2;
   logic       sel1;

   always_comb
   begin
      sel2      = a_lo[1] ? mask[3:2] : mask[1:0];
      sel1      = mask[a_lo];
      be_n      = ~mask;
      is_addr   = 4'h0;
      lanes     = mask;
      bus_wdata = wdata;
      rword     = din;
      case (size)
         emsd_pkg::SZ16:
         begin
            // Spare enable 2 has no meaning here and is held inactive
            be_n      = {a_lo[1], 1'b1, ~sel2};
            is_addr   = 4'h8;
            lanes     = {2'h0, sel2};
            bus_wdata = {16'h0, a_lo[1] ? wdata[31:16] : wdata[15:0]};
            rword     = a_lo[1] ? {din[15:0], 16'h0} : {16'h0, din[15:0]};
         end
         emsd_pkg::SZ8:
         begin
            be_n      = {a_lo[1], a_lo[0], 1'b1, ~sel1};
            is_addr   = 4'hc;
            lanes     = {3'h0, sel1};
            bus_wdata = {24'h0, wdata[{a_lo, 3'h0} +: 8]};
            rword     = 32'({24'h0, din[7:0]} << {a_lo, 3'h0});
         end
         default:
         begin
            be_n = ~mask;
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- verilog/emsd_strobe_decoder.sv ----
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module emsd_strobe_decoder
#(
   parameter int COL_BITS = 10
)
(
   input  wire logic                SYS_CLK,
   input  wire logic                RST,
   input  wire logic [31:0]         S_AXI_AWADDR,
   input  wire logic                S_AXI_AWVALID,
   output logic                     S_AXI_AWREADY,
   input  wire logic [31:0]         S_AXI_WDATA,
   input  wire logic [3:0]          S_AXI_WSTRB,
   input  wire logic                S_AXI_WVALID,
   output logic                     S_AXI_WREADY,
   output logic [1:0]               S_AXI_BRESP,
   output logic                     S_AXI_BVALID,
   input  wire logic                S_AXI_BREADY,
   input  wire logic [31:0]         S_AXI_ARADDR,
   input  wire logic                S_AXI_ARVALID,
   output logic                     S_AXI_ARREADY,
   output logic [31:0]              S_AXI_RDATA,
   output logic [1:0]               S_AXI_RRESP,
   output logic                     S_AXI_RVALID,
   input  wire logic                S_AXI_RREADY,
   input  wire logic                REQ_VALID,
   input  wire emsd_pkg::emsd_req_t REQ,
   output logic                     REQ_READY,
   input  wire logic                RFSH_REQ,
   output logic                     RFSH_ACK,
   output logic                     INT_SRAM_SEL,
   output logic [1:0]               INT_REGION,
   output logic                     PERIPH_SEL,
   output logic                     EXT_DONE,
   output logic [31:0]              EXT_RDATA,
   output emsd_pkg::emsd_pins_t     EXT_PINS,
   input  wire logic [31:0]         EXT_DATA_IN,
   input  wire logic                WAIT_REQUEST
);
   typedef struct packed {
      emsd_pkg::emsd_state_t         st;
      logic [3:0]                    cnt;
      logic [31:0]                   addr;
      logic [31:0]                   wdata;
      logic [3:0]                    mask;
      logic                          wr;
      logic [1:0]                    bank;
      emsd_pkg::emsd_pins_t          pins;
      logic                          done;
      logic                          rf_ack;
      logic                          int_sel;
      logic [1:0]                    region;
      logic                          per_sel;
      logic [31:0]                   rdata;
      emsd_pkg::emsd_bank_cfg_t [3:0] cfg;
      logic [3:0]                    cas_byte;
      logic [3:0]                    rf_ph;
      logic                          bvalid;
      logic [1:0]                    bresp;
      logic                          rvalid;
      logic [31:0]                   rbus;
      logic [1:0]                    rresp;
   } emsd_ctl_t;

   emsd_ctl_t                q;
   emsd_ctl_t                n;
   emsd_pkg::emsd_bank_cfg_t c;
   logic                     accept;
   logic                     aw_take;
   logic                     ar_take;
   logic [1:0]               req_bank;
   logic                     req_sram;
   logic                     req_periph;
   logic                     start_ext;
   logic [31:0]              sel_addr;
   logic [3:0]               sel_mask;
   logic [31:0]              sel_wdata;
   logic [1:0]               sel_bank;
   logic [3:0]               m_be_n;
   logic [3:0]               m_is_addr;
   logic [3:0]               m_lanes;
   logic [31:0]              m_wdata;
   logic [31:0]              m_rword;
   logic [31:0]              wmask;
   logic [31:0]              status;
   logic                     mix_bad;
   logic                     byte_bank;
   logic                     be_dir;
   logic [1:0]               ras_idx;
   logic [3:0]               be_row;

   // Phases to whole cycles, rounded up
   function automatic logic [3:0] ph2cyc(input logic [3:0] ph);
      logic [4:0] t;
      t = (5'(ph) + 5'(emsd_pkg::PHASES_PER_CYCLE - 1)) >> 1;
      return t[3:0];
   endfunction

   function automatic logic [3:0] col_cyc(input logic [3:0] ph);
      logic [3:0] t;
      t = ph2cyc(ph);
      return (t == 4'h0) ? 4'h1 : t;
   endfunction

   // Bank order follows signed addresses: 8xxx bank 0 up to 4xxx bank 3
   assign req_bank   = {~REQ.addr[31], REQ.addr[30]};
   assign req_sram   = (REQ.addr - emsd_pkg::SRAM_BASE) < emsd_pkg::SRAM_BYTES;
   assign req_periph = (req_bank == emsd_pkg::BANK_PERIPH) && REQ.device;
   assign REQ_READY  = (q.st == emsd_pkg::S_IDLE) && !RFSH_REQ;
   assign accept     = REQ_VALID && REQ_READY;
   assign start_ext  = accept && !req_sram && !req_periph;
   assign sel_addr   = start_ext ? REQ.addr : q.addr;
   assign sel_mask   = start_ext ? REQ.mask : q.mask;
   assign sel_wdata  = start_ext ? REQ.wdata : q.wdata;
   assign sel_bank   = start_ext ? req_bank : q.bank;
   assign c          = q.cfg[sel_bank];

   assign aw_take       = S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid;
   assign S_AXI_AWREADY = aw_take;
   assign S_AXI_WREADY  = aw_take;
   assign ar_take       = S_AXI_ARVALID && !q.rvalid;
   assign S_AXI_ARREADY = !q.rvalid;
   assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                   {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};

   // Byte-mode banks of 32 or 8 bits cannot share the strobes with bank mode
   always_comb
   begin
      mix_bad = 1'b0;
      if (q.cas_byte != 4'h0 && q.cas_byte != 4'hf)
      begin
         mix_bad = (q.cas_byte != 4'h3);
         for (int i = 0; i < 4; i++)
         begin
            if (q.cfg[i].mux && q.cas_byte[i] && q.cfg[i].size != emsd_pkg::SZ16)
            begin
               mix_bad = 1'b1;
            end
         end
      end
   end

   assign status = {27'h0, WAIT_REQUEST, q.bank, mix_bad, q.st != emsd_pkg::S_IDLE};

   emsd_lane_map u_lane_map
   (
      .size      (c.size),
      .a_lo      (sel_addr[1:0]),
      .mask      (sel_mask),
      .wdata     (sel_wdata),
      .din       (EXT_DATA_IN),
      .be_n      (m_be_n),
      .is_addr   (m_is_addr),
      .lanes     (m_lanes),
      .bus_wdata (m_wdata),
      .rword     (m_rword)
   );

   always_comb
   begin
      n         = q;
      n.done    = 1'b0;
      n.rf_ack  = 1'b0;
      n.int_sel = 1'b0;
      n.per_sel = 1'b0;
      byte_bank = 1'b0;
      be_dir    = 1'b0;
      ras_idx   = 2'h0;
      be_row    = 4'hf;
      if (q.bvalid && S_AXI_BREADY)
      begin
         n.bvalid = 1'b0;
      end
      if (aw_take)
      begin
         n.bvalid = 1'b1;
         n.bresp  = emsd_pkg::RESP_OKAY;
         if (S_AXI_AWADDR[31:5] != 27'h0)
         begin
            n.bresp = emsd_pkg::RESP_SLVERR;
         end
         else
         begin
            case (S_AXI_AWADDR[7:0])
               emsd_pkg::BANK0_CFG_OFFSET, emsd_pkg::BANK1_CFG_OFFSET,
               emsd_pkg::BANK2_CFG_OFFSET, emsd_pkg::BANK3_CFG_OFFSET:
               begin
                  n.cfg[S_AXI_AWADDR[3:2]] = emsd_pkg::emsd_bank_cfg_t'(
                     emsd_pkg::BANK_CFG_W'((32'(q.cfg[S_AXI_AWADDR[3:2]]) & ~wmask)
                                           | (S_AXI_WDATA & wmask)));
               end
               emsd_pkg::CAS_MODE_OFFSET:
               begin
                  if (S_AXI_WSTRB[0]) n.cas_byte = S_AXI_WDATA[3:0];
               end
               emsd_pkg::RFSH_TIME_OFFSET:
               begin
                  if (S_AXI_WSTRB[0]) n.rf_ph = S_AXI_WDATA[3:0];
               end
               emsd_pkg::STATUS_OFFSET, emsd_pkg::FREE_LOC_OFFSET:
               begin
                  n.bresp = emsd_pkg::RESP_OKAY;
               end
               default:
               begin
                  n.bresp = emsd_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
      if (q.rvalid && S_AXI_RREADY)
      begin
         n.rvalid = 1'b0;
      end
      if (ar_take)
      begin
         n.rvalid = 1'b1;
         n.rresp  = emsd_pkg::RESP_OKAY;
         n.rbus   = 32'h0;
         if (S_AXI_ARADDR[31:5] != 27'h0)
         begin
            n.rresp = emsd_pkg::RESP_SLVERR;
         end
         else
         begin
            case (S_AXI_ARADDR[7:0])
               emsd_pkg::BANK0_CFG_OFFSET, emsd_pkg::BANK1_CFG_OFFSET,
               emsd_pkg::BANK2_CFG_OFFSET, emsd_pkg::BANK3_CFG_OFFSET:
                  n.rbus = 32'(q.cfg[S_AXI_ARADDR[3:2]]);
               emsd_pkg::CAS_MODE_OFFSET:  n.rbus = {28'h0, q.cas_byte};
               emsd_pkg::RFSH_TIME_OFFSET: n.rbus = {28'h0, q.rf_ph};
               emsd_pkg::STATUS_OFFSET:    n.rbus = status;
               emsd_pkg::FREE_LOC_OFFSET:  n.rbus = emsd_pkg::FREE_BASE;
               default:                    n.rresp = emsd_pkg::RESP_SLVERR;
            endcase
         end
      end

      case (q.st)
         emsd_pkg::S_IDLE:
         begin
            if (RFSH_REQ)
            begin
               n.st  = emsd_pkg::S_RFSH;
               n.cnt = col_cyc(q.rf_ph);
            end
            else if (accept && req_sram)
            begin
               n.int_sel = 1'b1;
               n.region  = (REQ.addr < emsd_pkg::TRAP_BASE) ? emsd_pkg::RGN_CHAN :
                           (REQ.addr < emsd_pkg::FREE_BASE) ? emsd_pkg::RGN_TRAP :
                           emsd_pkg::RGN_FREE;
            end
            else if (accept && req_periph)
            begin
               n.per_sel = 1'b1;
            end
            else if (start_ext)
            begin
               n.addr  = REQ.addr;
               n.wdata = REQ.wdata;
               n.mask  = REQ.mask;
               n.wr    = REQ.write;
               n.bank  = req_bank;
               // Zero row time skips the row period for plain memories
               if (ph2cyc(c.row_ph) != 4'h0)
               begin
                  n.st  = emsd_pkg::S_ROW;
                  n.cnt = ph2cyc(c.row_ph);
               end
               else
               begin
                  n.st  = emsd_pkg::S_COL;
                  n.cnt = col_cyc(c.col_ph);
               end
            end
         end
         emsd_pkg::S_ROW:
         begin
            if (!WAIT_REQUEST)
            begin
               n.cnt = q.cnt - 4'h1;
               if (q.cnt == 4'h1)
               begin
                  n.st  = emsd_pkg::S_COL;
                  n.cnt = col_cyc(c.col_ph);
               end
            end
         end
         emsd_pkg::S_COL:
         begin
            if (!WAIT_REQUEST)
            begin
               n.cnt = q.cnt - 4'h1;
               if (q.cnt == 4'h1)
               begin
                  n.st   = emsd_pkg::S_IDLE;
                  n.done = 1'b1;
                  if (!q.wr) n.rdata = m_rword;
               end
            end
         end
         emsd_pkg::S_RFSH:
         begin
            n.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h1)
            begin
               n.st     = emsd_pkg::S_IDLE;
               n.rf_ack = 1'b1;
            end
         end
         default:
         begin
            n.st = emsd_pkg::S_IDLE;
         end
      endcase

      n.pins = emsd_pkg::PINS_IDLE;
      ras_idx = (sel_bank == 2'h3) ? 2'h2 : sel_bank;
      byte_bank = c.mux && q.cas_byte[sel_bank];
      be_dir = n.wr ? c.be_wr : c.be_rd;
      be_row = m_be_n | ~m_is_addr;
      if (n.st == emsd_pkg::S_ROW || n.st == emsd_pkg::S_COL)
      begin
         n.pins.addr = (n.st == emsd_pkg::S_ROW && c.mux) ?
                       22'(sel_addr >> (2 + COL_BITS)) : sel_addr[23:2];
         n.pins.be_n = (n.st == emsd_pkg::S_COL && be_dir) ? m_be_n : be_row;
         if (sel_bank != emsd_pkg::BANK_PERIPH && (c.mux || c.gp_row))
         begin
            n.pins.ras_n[ras_idx] = 1'b0;
         end
      end
      if (n.st == emsd_pkg::S_COL)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (q.cas_byte[i])
            begin
               // Lanes already reflect width, so a 16-bit bank never touches 2 and 3
               if (byte_bank && m_lanes[i]) n.pins.cas_n[i] = 1'b0;
            end
            else if (sel_bank == 2'(i) && (c.mux || c.gp_col))
            begin
               n.pins.cas_n[i] = 1'b0;
            end
         end
         n.pins.dout = m_wdata;
         n.pins.doe  = n.wr ? m_lanes : 4'h0;
      end
      if (n.st == emsd_pkg::S_RFSH)
      begin
         n.pins.cas_n = ~q.cas_byte;
      end
      if ((q.st == emsd_pkg::S_ROW || q.st == emsd_pkg::S_COL) && WAIT_REQUEST)
      begin
         n.pins = q.pins;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         q          <= '0;
         q.cfg      <= {4{emsd_pkg::BANK_CFG_RST}};
         q.rf_ph    <= emsd_pkg::RFSH_PH_RST;
         q.cas_byte <= emsd_pkg::CAS_BYTE_RST;
         q.pins     <= emsd_pkg::PINS_IDLE;
      end
      else
      begin
         q <= n;
      end
   end

   assign S_AXI_BRESP  = q.bresp;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_RDATA  = q.rbus;
   assign S_AXI_RRESP  = q.rresp;
   assign S_AXI_RVALID = q.rvalid;
   assign RFSH_ACK     = q.rf_ack;
   assign INT_SRAM_SEL = q.int_sel;
   assign INT_REGION   = q.region;
   assign PERIPH_SEL   = q.per_sel;
   assign EXT_DONE     = q.done;
   assign EXT_RDATA    = q.rdata;
   assign EXT_PINS     = q.pins;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sram_wins_a: assert property (accept && req_sram
      |=> INT_SRAM_SEL && q.st == emsd_pkg::S_IDLE && EXT_PINS.ras_n == 3'h7)
      else $error("sram access started external cycle");
   sram_region_a: assert property (accept && req_sram && REQ.addr >= emsd_pkg::FREE_BASE
      |=> INT_REGION == emsd_pkg::RGN_FREE) else $error("free region misdecoded");
   periph_route_a: assert property (accept && req_periph && !req_sram
      |=> PERIPH_SEL && q.st == emsd_pkg::S_IDLE) else $error("peripheral access went external");
   bank_pick_a: assert property (start_ext |=> q.bank == $past(req_bank))
      else $error("bank not from top address bits");
   wait_freeze_a: assert property ((q.st == emsd_pkg::S_ROW || q.st == emsd_pkg::S_COL)
      && WAIT_REQUEST |=> $stable(EXT_PINS) && $stable(q.cnt))
      else $error("wait did not freeze cycle");
   refresh_cas_a: assert property (q.st == emsd_pkg::S_RFSH
      |-> (EXT_PINS.cas_n & q.cas_byte) == 4'h0) else $error("byte strobe high in refresh");
   narrow_lane_a: assert property (q.st == emsd_pkg::S_COL
      && q.cfg[q.bank].size == emsd_pkg::SZ8 |-> EXT_PINS.doe[3:1] == 3'h0
      && EXT_PINS.be_n[3:2] == q.addr[1:0]) else $error("8-bit port lane or address bits wrong");
   half_addr_a: assert property (q.st == emsd_pkg::S_COL
      && q.cfg[q.bank].size == emsd_pkg::SZ16 |-> EXT_PINS.be_n[3] == q.addr[1]
      && EXT_PINS.doe[3:2] == 2'h0) else $error("16-bit port mapping wrong");
   row_strobe_a: assert property (q.st == emsd_pkg::S_COL && q.bank == 2'h0 && q.cfg[0].mux
      |-> !EXT_PINS.ras_n[0]) else $error("row strobe missing");
   byte_cas_a: assert property (q.st == emsd_pkg::S_COL && q.cas_byte[3]
      && !EXT_PINS.cas_n[3] |-> q.cfg[q.bank].size == emsd_pkg::SZ32)
      else $error("strobe 3 on narrow bank");
   cycle_count_a: assert property ((q.st == emsd_pkg::S_ROW || q.st == emsd_pkg::S_COL)
      && !WAIT_REQUEST && q.cnt != 4'h1 |=> q.cnt == $past(q.cnt) - 4'h1)
      else $error("cycle counter lost");
   axi_read_a: assert property (ar_take |=> S_AXI_RVALID) else $error("read not answered");

   ext_read_c: cover property (start_ext && !REQ.write ##[1:40] EXT_DONE);
   waited_c: cover property (q.st == emsd_pkg::S_COL && WAIT_REQUEST [*3]);
   refresh_c: cover property (q.st == emsd_pkg::S_RFSH && q.cas_byte == 4'hf);
endmodule
`default_nettype wire

// ---- sim/emsd_ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module emsd_ext_mem_model
(
   input  wire logic                 clk,
   input  wire emsd_pkg::emsd_pins_t pins,
   input  wire logic                 slow,
   output logic      [31:0]          data_out,
   output logic                      wait_req
);
   logic [31:0] last_q = 32'h0;
   logic        wait_q = 1'b0;
   logic        sel;
   assign sel = pins.be_n != 4'hf && pins.doe == 4'h0;
   // Released bus shows the inverse each cycle so a stale sample cannot pass
   assign data_out = sel ? ({10'h0, pins.addr} ^ 32'h5a5a_0000) : ~last_q;
   assign wait_req = wait_q;
   always @(posedge clk)
   begin
      last_q <= data_out;
      wait_q <= slow & ~wait_q & (pins.be_n != 4'hf);
   end
endmodule
`default_nettype wire

// ---- sim/emsd_strobe_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module emsd_strobe_decoder_tb;
   logic                 SYS_CLK, RST = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
   logic                 S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
   logic                 REQ_VALID = 1'b0, RFSH_REQ = 1'b0, slow = 1'b0;
   logic                 S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic                 S_AXI_RVALID, REQ_READY, RFSH_ACK, INT_SRAM_SEL, PERIPH_SEL;
   logic                 EXT_DONE, WAIT_REQUEST;
   logic [31:0]          S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
   logic [31:0]          S_AXI_RDATA, EXT_RDATA, EXT_DATA_IN, rd;
   logic [3:0]           S_AXI_WSTRB = 4'hf, be_seen = 4'hf, cas_seen = 4'hf;
   logic [1:0]           S_AXI_BRESP, S_AXI_RRESP, INT_REGION, kind, rs;
   logic [7:0]           lane0 = 8'h0;
   logic [24:0]          row_seen = 25'h0;
   emsd_pkg::emsd_req_t  REQ = '0;
   emsd_pkg::emsd_pins_t EXT_PINS;
   int                   miscompares = 0, num_checks = 0, n;
   logic [31:0]          ra [9] = '{32'h8000_0000, 32'h8000_0040, 32'h8000_0140, 32'h8000_1ffc,
      32'h8000_2000, 32'h2000_0000, 32'h2000_0000, 32'h4000_0010, 32'hc000_0104};
   // Row code: device access, expected route (0 sram, 1 peripheral, 2 external), region
   logic [4:0]           rc [9] = '{5'h00, 5'h01, 5'h02, 5'h02, 5'h08, 5'h14, 5'h08, 5'h18, 5'h08};
   logic [3:0]           bes [3] = '{4'h9, 4'he, 4'ha};

   emsd_ext_mem_model u_emsd_ext_mem_model (.clk(SYS_CLK), .pins(EXT_PINS), .slow(slow),
      .data_out(EXT_DATA_IN), .wait_req(WAIT_REQUEST));
   emsd_strobe_decoder u_emsd_strobe_decoder (.SYS_CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .REQ_VALID, .REQ, .REQ_READY, .RFSH_REQ,
      .RFSH_ACK, .INT_SRAM_SEL, .INT_REGION, .PERIPH_SEL, .EXT_DONE, .EXT_RDATA, .EXT_PINS,
      .EXT_DATA_IN, .WAIT_REQUEST);

   initial
   begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   // First active cycle of an access is the one the device qualifies with its lanes
   always @(negedge SYS_CLK)
   begin
      if (EXT_PINS.be_n !== 4'hf && be_seen === 4'hf)
      begin
         be_seen <= EXT_PINS.be_n;
         lane0   <= EXT_PINS.dout[7:0];
      end
      if (EXT_PINS.cas_n !== 4'hf)
         cas_seen <= EXT_PINS.cas_n;
      // Row period is the only time a row strobe is low with every column strobe high
      if (EXT_PINS.ras_n !== 3'h7 && EXT_PINS.cas_n === 4'hf)
         row_seen <= {EXT_PINS.ras_n, EXT_PINS.addr};
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tmo(input int c);
      if (c >= 60)
      begin
         miscompares++;
         test_done();
      end
   endtask

   task automatic axi(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      S_AXI_AWADDR  <= a;
      S_AXI_ARADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= w;
      S_AXI_WVALID  <= w;
      S_AXI_ARVALID <= !w;
      S_AXI_BREADY  <= w;
      S_AXI_RREADY  <= !w;
      @(negedge SYS_CLK);
      for (n = 0; n < 60 && (w ? S_AXI_AWREADY : S_AXI_ARREADY) !== 1'b1; n++)
         @(negedge SYS_CLK);
      tmo(n);
      @(posedge SYS_CLK);
      S_AXI_AWVALID <= 1'b0;
      S_AXI_WVALID  <= 1'b0;
      S_AXI_ARVALID <= 1'b0;
      @(negedge SYS_CLK);
      for (n = 0; n < 60 && (w ? S_AXI_BVALID : S_AXI_RVALID) !== 1'b1; n++)
         @(negedge SYS_CLK);
      tmo(n);
      rs = w ? S_AXI_BRESP : S_AXI_RRESP;
      rd = S_AXI_RDATA;
      @(posedge SYS_CLK);
      S_AXI_BREADY  <= 1'b0;
      S_AXI_RREADY  <= 1'b0;
   endtask

   task automatic acc(input logic [31:0] a, input logic d, input logic w, input logic [3:0] m);
      @(posedge SYS_CLK);
      REQ_VALID <= 1'b1;
      REQ       <= '{addr: a, wdata: 32'h1234_5678, mask: m, write: w, device: d};
      @(negedge SYS_CLK);
      for (n = 0; n < 60 && REQ_READY !== 1'b1; n++)
         @(negedge SYS_CLK);
      tmo(n);
      @(posedge SYS_CLK);
      REQ_VALID <= 1'b0;
      kind = 2'h3;
      for (n = 0; n < 60 && kind == 2'h3; n++)
      begin
         @(negedge SYS_CLK);
         kind = INT_SRAM_SEL === 1'b1 ? 2'h0 : PERIPH_SEL === 1'b1 ? 2'h1 :
            EXT_DONE === 1'b1 ? 2'h2 : 2'h3;
      end
      tmo(n);
   endtask

   initial
   begin
      repeat (11) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk("reset pins", 32'h1, {31'h0, EXT_PINS === emsd_pkg::PINS_IDLE});
      @(posedge SYS_CLK);
      RST <= 1'b0;
      axi(1'b0, {24'h0, emsd_pkg::BANK0_CFG_OFFSET}, 32'h0);
      chk("bank0 cfg", 32'h0000_2058, rd);
      axi(1'b0, 32'h0000_0020, 32'h0);
      chk("unmapped resp", {30'h0, emsd_pkg::RESP_SLVERR}, {30'h0, rs});
      axi(1'b0, {24'h0, emsd_pkg::FREE_LOC_OFFSET}, 32'h0);
      chk("first free", emsd_pkg::FREE_BASE, rd);
      foreach (ra[i])
      begin
         acc(ra[i], rc[i][4], 1'b0, 4'hf);
         chk("route", {30'h0, rc[i][3:2]}, {30'h0, kind});
         if (rc[i][3:2] == 2'h0)
            chk("region", {30'h0, rc[i][1:0]}, {30'h0, INT_REGION});
         if (rc[i][3:2] == 2'h2)
            chk("read word", {10'h0, ra[i][23:2]} ^ 32'h5a5a_0000, EXT_RDATA);
         $display("route row %0d done", i);
      end
      for (int s = 0; s < 3; s++)
      begin
         axi(1'b1, 32'h0, 32'h0000_2058 | s);
         chk("write resp", {30'h0, emsd_pkg::RESP_OKAY}, {30'h0, rs});
         be_seen = 4'hf;
         acc(32'h8000_2002, 1'b0, 1'b1, s == 0 ? 4'h6 : 4'h4);
         chk("byte enables", {28'h0, bes[s]}, {28'h0, be_seen});
         if (s > 0)
            chk("lane0 data", 32'h34, {24'h0, lane0});
         $display("port size %0d done", s);
      end
      axi(1'b1, 32'h0, 32'h0000_2058);
      slow <= 1'b1;
      acc(32'h8000_4010, 1'b0, 1'b0, 4'hf);
      chk("wait read", 32'h5a5a_1004, EXT_RDATA);
      slow <= 1'b0;
      $display("wait test done");
      axi(1'b1, {24'h0, emsd_pkg::CAS_MODE_OFFSET}, 32'h3);
      cas_seen = 4'hf;
      @(posedge SYS_CLK);
      RFSH_REQ <= 1'b1;
      @(negedge SYS_CLK);
      chk("ready in refresh", 32'h0, {31'h0, REQ_READY});
      @(posedge SYS_CLK);
      RFSH_REQ <= 1'b0;
      for (n = 0; n < 60 && RFSH_ACK !== 1'b1; n++)
         @(negedge SYS_CLK);
      tmo(n);
      chk("refresh cas", 32'hc, {28'h0, cas_seen});
      $display("refresh test done");
      // Bank 0 as 16-bit multiplexed memory, byte strobes 0 and 1, one row and one column cycle
      axi(1'b1, 32'h0, 32'h0000_115d);
      acc(32'h8034_5806, 1'b0, 1'b0, 4'h4);
      chk("row address", {7'h0, 3'h6, 22'h08_0345}, {7'h0, row_seen});
      chk("byte cas", 32'he, {28'h0, cas_seen});
      chk("half read", 32'h1601_0000, EXT_RDATA);
      $display("multiplexed test done");
      @(posedge SYS_CLK);
      RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      axi(1'b0, {24'h0, emsd_pkg::BANK0_CFG_OFFSET}, 32'h0);
      chk("cfg after reset", 32'h0000_2058, rd);
      $display("reset test done");
      test_done();
   end
endmodule
`default_nettype wire
